// ==== design/ltlsk_keeper.sv ====
`default_nettype none
module ltlsk_keeper #(
    parameter logic signed [7:0] ACC_INIT = 8'sd0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic preset,
    input wire logic satLock,
    input wire logic secTick,
    input wire ltlsk_pkg::ltlsk_stamp_t utcNow,
    input wire logic signed [7:0] gpsMinusUtc,
    input wire logic gpsMinusUtcValid,
    input wire logic leapIns,
    input wire logic leapDel,
    input wire logic [11:0] leapYear,
    input wire logic [3:0] leapMonth,
    input wire logic [4:0] leapDay,
    input wire logic zoneWrite,
    input wire logic signed [7:0] zoneHourIn,
    input wire logic signed [7:0] zoneMinIn,
    input wire logic zoneMinGiven,
    input wire logic zoneRoundUp,
    input wire logic edgeWrite,
    input wire logic edgeFalling,
    input wire logic queryValid,
    input wire ltlsk_pkg::ltlsk_query_t querySel,
    output logic answerValid,
    output ltlsk_pkg::ltlsk_answer_t answer,
    output logic [7:0] powerupStatus,
    output logic ppsFalling,
    output ltlsk_pkg::ltlsk_stamp_t localNow
);
    ////////////////////////////////////////////////////////////////////
    // Stored state
    logic firstLock_r; // Lock seen since reset or preset
    logic signed [4:0] zoneHr_r; // Zone hours
    logic signed [6:0] zoneMin_r; // Zone minutes
    logic edgeFall_r; // On-time edge select
    logic signed [7:0] acc_r; // GPS minus UTC seconds
    logic accLoaded_r; // Count taken from power-on
    logic insPend_r; // Insertion scheduled
    logic delPend_r; // Deletion scheduled
    logic [5:0] prevSec_r; // Seconds at previous tick
    logic lockS1_r; // Lock synchroniser first stage
    logic lockS2_r; // Lock synchroniser second stage
    ltlsk_pkg::ltlsk_answer_t ans_r; // Registered answer
    logic ansV_r; // Answer strobe
    ltlsk_pkg::ltlsk_stamp_t loc_r; // Local stamp register

    ////////////////////////////////////////////////////////////////////
    // Zone input clamp and rounding
    wire signed [7:0] hrRnd = zoneRoundUp ? zoneHourIn + 8'sd1 : zoneHourIn;
    wire signed [7:0] mnRaw = zoneMinGiven ? zoneMinIn : 8'sd0;
    wire signed [7:0] mnRnd = (zoneRoundUp && zoneMinGiven) ? mnRaw + 8'sd1 : mnRaw;
    wire signed [4:0] hrClamp = (hrRnd > 8'sd12) ? ltlsk_pkg::ZONE_HR_MAX :
        (hrRnd < -8'sd12) ? -ltlsk_pkg::ZONE_HR_MAX : hrRnd[4:0];
    wire signed [6:0] mnClamp = (mnRnd > 8'sd59) ? ltlsk_pkg::ZONE_MIN_MAX :
        (mnRnd < -8'sd59) ? -ltlsk_pkg::ZONE_MIN_MAX : mnRnd[6:0];

    ////////////////////////////////////////////////////////////////////
    // Local time from UTC plus offset, with carries
    wire signed [7:0] sumMin = 8'(signed'({2'b0, utcNow.minute})) + 8'(zoneMin_r);
    wire minBorrow = sumMin < 0;
    wire minCarry = sumMin > 8'sd59;
    wire signed [7:0] locMinS = minBorrow ? sumMin + 8'sd60 : minCarry ? sumMin - 8'sd60 : sumMin;
    wire signed [7:0] sumHr = 8'(signed'({3'b0, utcNow.hour})) + 8'(zoneHr_r)
        + (minCarry ? 8'sd1 : 8'sd0) - (minBorrow ? 8'sd1 : 8'sd0);
    wire dayBack = sumHr < 0;
    wire dayFwd = sumHr > 8'sd23;
    wire signed [7:0] locHrS = dayBack ? sumHr + 8'sd24 : dayFwd ? sumHr - 8'sd24 : sumHr;
    // Days in a month, leap years by four (valid to 2099)
    function automatic logic [4:0] ltlsk_mdays(input logic [11:0] y, input logic [3:0] m);
        case (m)
            4'h2: ltlsk_mdays = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hB: ltlsk_mdays = 5'd30;
            default: ltlsk_mdays = 5'd31;
        endcase
    endfunction : ltlsk_mdays
    wire [3:0] prevMon = (utcNow.month == 4'h1) ? 4'hC : utcNow.month - 4'h1;
    wire [11:0] prevMonYr = (utcNow.month == 4'h1) ? utcNow.year - 12'h1 : utcNow.year;
    wire lastDay = utcNow.day == ltlsk_mdays(utcNow.year, utcNow.month);
    ltlsk_pkg::ltlsk_stamp_t locNxt;
    // Date roll forward or back
    always_comb begin
        locNxt = utcNow;
        locNxt.minute = locMinS[5:0];
        locNxt.hour = locHrS[4:0];
        if (dayFwd) begin
            if (lastDay) begin
                locNxt.day = 5'h1;
                locNxt.month = (utcNow.month == 4'hC) ? 4'h1 : utcNow.month + 4'h1;
                locNxt.year = (utcNow.month == 4'hC) ? utcNow.year + 12'h1 : utcNow.year;
            end else begin
                locNxt.day = utcNow.day + 5'h1;
            end
        end else if (dayBack) begin
            if (utcNow.day == 5'h1) begin
                locNxt.day = ltlsk_mdays(prevMonYr, prevMon);
                locNxt.month = prevMon;
                locNxt.year = prevMonYr;
            end else begin
                locNxt.day = utcNow.day - 5'h1;
            end
        end
        // Keep year inside reported window
        if (locNxt.year < ltlsk_pkg::YEAR_MIN) begin
            locNxt.year = ltlsk_pkg::YEAR_MIN;
        end else if (locNxt.year > ltlsk_pkg::YEAR_MAX) begin
            locNxt.year = ltlsk_pkg::YEAR_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Leap second detection: 60 seen then midnight means insertion done
    wire midnightTick = secTick && utcNow.second == 6'd0 && utcNow.minute == 6'd0
        && utcNow.hour == 5'd0;
    wire insDone = midnightTick && prevSec_r == 6'd60;
    wire delDone = midnightTick && prevSec_r == 6'd58 && delPend_r;
    wire lockSeen = lockS2_r;

    ////////////////////////////////////////////////////////////////////
    // Text digits for the time string
    function automatic logic [15:0] ltlsk_dig2(input logic [5:0] v);
        ltlsk_dig2 = {ltlsk_pkg::ASC_ZERO + 8'(v / 6'd10), ltlsk_pkg::ASC_ZERO + 8'(v % 6'd10)};
    endfunction : ltlsk_dig2
    wire [79:0] timeText = {ltlsk_pkg::ASC_QUOTE, ltlsk_dig2({1'b0, loc_r.hour}),
        ltlsk_pkg::ASC_COLON, ltlsk_dig2(loc_r.minute), ltlsk_pkg::ASC_COLON,
        ltlsk_dig2(loc_r.second), ltlsk_pkg::ASC_QUOTE};
    wire anyPend = insPend_r || delPend_r;
    wire [5:0] minLen = insPend_r ? ltlsk_pkg::MIN_LEN_INS :
        delPend_r ? ltlsk_pkg::MIN_LEN_DEL : ltlsk_pkg::MIN_LEN_NONE;
    wire needPend = querySel == ltlsk_pkg::LTLSK_Q_LDATE || querySel == ltlsk_pkg::LTLSK_Q_LDUR;
    wire refuse = !firstLock_r || (needPend && !anyPend);

    // Answer selection
    ltlsk_pkg::ltlsk_answer_t ansNxt;
    always_comb begin
        ansNxt = '0;
        ansNxt.error = refuse;
        ansNxt.errCode = refuse ? ltlsk_pkg::ERR_CONTEXT : 16'sd0;
        case (querySel)
            ltlsk_pkg::LTLSK_Q_TIME: begin
                ansNxt.f0 = 16'(loc_r.hour);
                ansNxt.f1 = 16'(loc_r.minute);
                ansNxt.f2 = 16'(loc_r.second);
            end
            ltlsk_pkg::LTLSK_Q_DATE: begin
                ansNxt.f0 = 16'(loc_r.year);
                ansNxt.f1 = 16'(loc_r.month);
                ansNxt.f2 = 16'(loc_r.day);
            end
            ltlsk_pkg::LTLSK_Q_STRING: ansNxt.text = timeText;
            ltlsk_pkg::LTLSK_Q_ZONE: begin
                ansNxt.f0 = 16'(zoneHr_r);
                ansNxt.f1 = 16'(zoneMin_r);
            end
            ltlsk_pkg::LTLSK_Q_EDGE: begin
                ansNxt.text = {edgeFall_r ? ltlsk_pkg::TXT_FALL : ltlsk_pkg::TXT_RIS, 48'h0};
            end
            ltlsk_pkg::LTLSK_Q_ACC: ansNxt.f0 = 16'(acc_r);
            ltlsk_pkg::LTLSK_Q_LDATE: begin
                ansNxt.f0 = 16'(leapYear);
                ansNxt.f1 = 16'(leapMonth);
                ansNxt.f2 = 16'(leapDay);
            end
            ltlsk_pkg::LTLSK_Q_LDUR: ansNxt.f0 = 16'(minLen);
            ltlsk_pkg::LTLSK_Q_LSTATE: ansNxt.f0 = anyPend ? 16'sd1 : 16'sd0;
            default: ansNxt.error = 1'b1;
        endcase
        // Edge and zone need no lock
        if (querySel == ltlsk_pkg::LTLSK_Q_EDGE || querySel == ltlsk_pkg::LTLSK_Q_ZONE) begin
            ansNxt.error = 1'b0;
            ansNxt.errCode = 16'sd0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock synchroniser and first-lock flag
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lockS1_r <= 1'b0;
            lockS2_r <= 1'b0;
            firstLock_r <= 1'b0;
        end else begin
            lockS1_r <= satLock;
            lockS2_r <= lockS1_r;
            firstLock_r <= lockSeen || (firstLock_r && !preset);
        end
    end

    // Settings: preset values; reset stands in for non-volatile load
    always_ff @(posedge clk) begin
        if (!reset_n || preset) begin
            zoneHr_r <= 5'sd0;
            zoneMin_r <= 7'sd0;
            edgeFall_r <= 1'b0;
        end else begin
            if (zoneWrite) begin
                zoneHr_r <= hrClamp;
                zoneMin_r <= mnClamp;
            end
            if (edgeWrite) begin
                edgeFall_r <= edgeFalling;
            end
        end
    end

    // Leap count and pending flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc_r <= ACC_INIT;
            accLoaded_r <= 1'b0;
            insPend_r <= 1'b0;
            delPend_r <= 1'b0;
            prevSec_r <= 6'd0;
        end else begin
            if (gpsMinusUtcValid && !accLoaded_r) begin
                acc_r <= gpsMinusUtc;
                accLoaded_r <= 1'b1;
            end else if (insDone) begin
                acc_r <= acc_r + 8'sd1;
            end else if (delDone) begin
                acc_r <= acc_r - 8'sd1;
            end
            insPend_r <= leapIns && !insDone;
            delPend_r <= leapDel && !leapIns && !delDone;
            if (secTick) begin
                prevSec_r <= utcNow.second;
            end
        end
    end

    // Local stamp and answer registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            loc_r <= '0;
            ans_r <= '0;
            ansV_r <= 1'b0;
        end else begin
            loc_r <= locNxt;
            ansV_r <= queryValid;
            if (queryValid) begin
                ans_r <= ansNxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign answerValid = ansV_r;
    assign answer = ans_r;
    assign powerupStatus = 8'(firstLock_r) << ltlsk_pkg::FIRST_LOCK_BIT;
    assign ppsFalling = edgeFall_r;
    assign localNow = loc_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_ask_unlocked;
        queryValid && !firstLock_r && querySel != ltlsk_pkg::LTLSK_Q_EDGE
            && querySel != ltlsk_pkg::LTLSK_Q_ZONE;
    endsequence

    // Gated query before lock
    a_unlocked_refuse: assert property (@(posedge clk) disable iff (!reset_n)
        s_ask_unlocked |=> answerValid && answer.error && answer.errCode == -16'sd230)
        else $error("query before lock not refused");

    // Status bit rises only on lock
    a_status_bit: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(powerupStatus[ltlsk_pkg::FIRST_LOCK_BIT]) |-> $past(lockSeen))
        else $error("status bit rose without lock");

    // Preset restores defaults
    a_preset_zone: assert property (@(posedge clk) disable iff (!reset_n)
        preset |=> zoneHr_r == 5'sd0 && zoneMin_r == 7'sd0 && !ppsFalling)
        else $error("preset did not clear zone");

    // Stored zone inside limits
    a_zone_range: assert property (@(posedge clk) disable iff (!reset_n)
        zoneHr_r <= 5'sd12 && zoneHr_r >= -5'sd12 && zoneMin_r <= 7'sd59
        && zoneMin_r >= -7'sd59) else $error("zone out of range");

    // Insertion adds one
    a_ins_count: assert property (@(posedge clk) disable iff (!reset_n)
        insDone && accLoaded_r |=> acc_r == $past(acc_r) + 8'sd1)
        else $error("insertion not counted");

    // Deletion takes one
    a_del_count: assert property (@(posedge clk) disable iff (!reset_n)
        delDone && accLoaded_r && !insDone |=> acc_r == $past(acc_r) - 8'sd1)
        else $error("deletion not counted");

    // Date and length need a pending leap
    a_nopend_refuse: assert property (@(posedge clk) disable iff (!reset_n)
        queryValid && needPend && !anyPend |=> answer.error)
        else $error("leap query without pending not refused");

    // Pending query answers once locked
    a_state_valid: assert property (@(posedge clk) disable iff (!reset_n)
        queryValid && firstLock_r && querySel == ltlsk_pkg::LTLSK_Q_LSTATE
        |=> !answer.error && answer.f0 == 16'($past(anyPend)))
        else $error("pending query wrongly refused");

    // First lock sticks until preset
    a_lock_hold: assert property (@(posedge clk) disable iff (!reset_n)
        firstLock_r && !preset |=> firstLock_r) else $error("first lock lost");

    // Preset without lock clears it
    a_lock_clear: assert property (@(posedge clk) disable iff (!reset_n)
        preset && !lockSeen |=> !powerupStatus[ltlsk_pkg::FIRST_LOCK_BIT])
        else $error("preset left first lock set");

    // Omitted minutes store zero
    a_zone_nomin: assert property (@(posedge clk) disable iff (!reset_n)
        zoneWrite && !preset && !zoneMinGiven |=> zoneMin_r == 7'sd0)
        else $error("omitted minutes not zero");

    // Edge select follows a write
    a_edge_write: assert property (@(posedge clk) disable iff (!reset_n)
        edgeWrite && !preset |=> ppsFalling == $past(edgeFalling))
        else $error("edge select not stored");

    // First offset value loads the count
    a_acc_load: assert property (@(posedge clk) disable iff (!reset_n)
        gpsMinusUtcValid && !accLoaded_r |=> acc_r == $past(gpsMinusUtc))
        else $error("leap count not loaded");

    // Pending insertion gives 61
    a_dur_insert: assert property (@(posedge clk) disable iff (!reset_n)
        queryValid && firstLock_r && querySel == ltlsk_pkg::LTLSK_Q_LDUR && insPend_r
        |=> answer.f0 == 16'(ltlsk_pkg::MIN_LEN_INS))
        else $error("insertion minute length wrong");

    // Seconds pass through unshifted
    a_local_sec: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> localNow.second == $past(utcNow.second))
        else $error("local seconds differ from UTC");

    // Carries keep local time in range
    a_local_range: assert property (@(posedge clk) disable iff (!reset_n)
        localNow.hour <= 5'h17 && localNow.minute <= 6'h3B)
        else $error("local time out of range");

    // Time text framed by quotes and colons
    a_text_frame: assert property (@(posedge clk) disable iff (!reset_n)
        queryValid && !refuse && querySel == ltlsk_pkg::LTLSK_Q_STRING
        |=> answer.text[79:72] == ltlsk_pkg::ASC_QUOTE
        && answer.text[7:0] == ltlsk_pkg::ASC_QUOTE
        && answer.text[55:48] == ltlsk_pkg::ASC_COLON
        && answer.text[31:24] == ltlsk_pkg::ASC_COLON)
        else $error("time text framing wrong");
endmodule : ltlsk_keeper
`default_nettype wire

// ==== design/ltlsk_pkg.sv ====
// Function
// - Queries before first lock, except zone and edge, answer error -230
// - First-lock flag is status bit 2
// - Time string is quoted HH:MM:SS, 24-hour
// - Zone hours -12..+12, rounded to integer
// - Zone minutes -59..+59, default zero
// - Preset zeroes zone; otherwise retained
// - Local time equals UTC plus zone offset
// - Zone query returns hours then minutes
// - Host picks on-time edge; rising default
// - Polarity query answers RIS or FALL
// - Power-on loads count as GPS minus UTC
// - Inserted leap second increments the count
// - Deleted leap second decrements the count
// - Leap date query gives UTC year, month, day
// - Date and duration error when none pending
// - Minute length 59, 60 or 61
// - Pending query returns 1 or 0
// - Pending query valid when none scheduled
// - Seconds reach 60 only in insertion
// - Local date 1994..2077, zone shifted
`default_nettype none
package ltlsk_pkg;
    // Query error code
    localparam logic signed [15:0] ERR_CONTEXT = -16'sd230;
    // First-lock bit in power-up status word
    localparam int FIRST_LOCK_BIT = 2;
    // Year window
    localparam logic [11:0] YEAR_MIN = 12'd1994;
    localparam logic [11:0] YEAR_MAX = 12'd2077;
    // Zone limits
    localparam logic signed [4:0] ZONE_HR_MAX = 5'sd12;
    localparam logic signed [6:0] ZONE_MIN_MAX = 7'sd59;
    // Minute lengths
    localparam logic [5:0] MIN_LEN_DEL = 6'd59;
    localparam logic [5:0] MIN_LEN_NONE = 6'd60;
    localparam logic [5:0] MIN_LEN_INS = 6'd61;
    // Polarity answer text, ASCII, left aligned
    localparam logic [31:0] TXT_RIS = 32'h52495320;
    localparam logic [31:0] TXT_FALL = 32'h46414C4C;
    localparam logic [7:0] ASC_ZERO = 8'h30;
    localparam logic [7:0] ASC_COLON = 8'h3A;
    localparam logic [7:0] ASC_QUOTE = 8'h22;

    // Query selector
    typedef enum logic [3:0] {
        LTLSK_Q_TIME = 4'h0,
        LTLSK_Q_DATE = 4'h1,
        LTLSK_Q_STRING = 4'h2,
        LTLSK_Q_ZONE = 4'h3,
        LTLSK_Q_EDGE = 4'h4,
        LTLSK_Q_ACC = 4'h5,
        LTLSK_Q_LDATE = 4'h6,
        LTLSK_Q_LDUR = 4'h7,
        LTLSK_Q_LSTATE = 4'h8
    } ltlsk_query_t;

    // Calendar date and time of day
    typedef struct packed {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } ltlsk_stamp_t;

    // Query answer: three signed fields, or text
    typedef struct packed {
        logic error;
        logic signed [15:0] errCode;
        logic signed [15:0] f0;
        logic signed [15:0] f1;
        logic signed [15:0] f2;
        logic [79:0] text;
    } ltlsk_answer_t;
endpackage : ltlsk_pkg
`default_nettype wire

// ==== testbench/local_time_leap_second_keeper_tb_top.sv ====
`default_nettype none
module local_time_leap_second_keeper_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, preset, satLock, secTick, gpsMinusUtcValid, leapIns, leapDel;
    logic zoneWrite, zoneMinGiven, zoneRoundUp, edgeWrite, edgeFalling, answerValid, ppsFalling;
    logic signed [7:0] gpsMinusUtc, zoneHourIn, zoneMinIn;
    logic [11:0] leapYear;
    logic [3:0] leapMonth;
    logic [4:0] leapDay;
    logic [7:0] powerupStatus;
    wire logic queryValid;
    wire ltlsk_pkg::ltlsk_query_t querySel;
    ltlsk_pkg::ltlsk_stamp_t utcNow, localNow;
    ltlsk_pkg::ltlsk_answer_t answer, lastAns;
    int n_errors = 0;
    int check_count = 0;

    ltlsk_keeper i_dut (
        .clk(clk), .reset_n(reset_n), .preset(preset), .satLock(satLock), .secTick(secTick),
        .utcNow(utcNow), .gpsMinusUtc(gpsMinusUtc), .gpsMinusUtcValid(gpsMinusUtcValid),
        .leapIns(leapIns), .leapDel(leapDel), .leapYear(leapYear), .leapMonth(leapMonth),
        .leapDay(leapDay), .zoneWrite(zoneWrite), .zoneHourIn(zoneHourIn),
        .zoneMinIn(zoneMinIn), .zoneMinGiven(zoneMinGiven), .zoneRoundUp(zoneRoundUp),
        .edgeWrite(edgeWrite), .edgeFalling(edgeFalling), .queryValid(queryValid),
        .querySel(querySel), .answerValid(answerValid), .answer(answer),
        .powerupStatus(powerupStatus), .ppsFalling(ppsFalling), .localNow(localNow)
    );
    // Host side of the command port
    ltlsk_host_model i_host (
        .clk(clk), .answerValid(answerValid), .answer(answer), .powerupStatus(powerupStatus),
        .queryValid(queryValid), .querySel(querySel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic print_verdict;
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // One comparison
    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Date and time builder
    function automatic ltlsk_pkg::ltlsk_stamp_t st(input int y, mo, d, h, mi, s);
        st = '{year: y[11:0], month: mo[3:0], day: d[4:0], hour: h[4:0], minute: mi[5:0],
            second: s[5:0]};
    endfunction : st

    // One-cycle strobe
    task automatic pulse(ref logic sig);
        @(posedge clk);
        #1;
        sig = 1'b1;
        @(posedge clk);
        #1;
        sig = 1'b0;
    endtask : pulse

    // New UTC second
    task automatic tick(input ltlsk_pkg::ltlsk_stamp_t s);
        utcNow = s;
        pulse(secTick);
    endtask : tick

    // Zone offset write
    task automatic setZone(input int h, input int m, input bit given, input bit up);
        zoneHourIn = h[7:0];
        zoneMinIn = m[7:0];
        zoneMinGiven = given;
        zoneRoundUp = up;
        pulse(zoneWrite);
    endtask : setZone

    // Query and judge error or the first n fields
    task automatic qchk(input ltlsk_pkg::ltlsk_query_t sel, input bit err, input int n,
        input int a, input int b, input int c);
        bit ok;
        i_host.ask(sel, lastAns, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end
        chk("error flag", err, lastAns.error);
        if (err) chk("error code", ltlsk_pkg::ERR_CONTEXT, lastAns.errCode);
        if (!err && n > 0) chk("field 0", a, lastAns.f0);
        if (!err && n > 1) chk("field 1", b, lastAns.f1);
        if (!err && n > 2) chk("field 2", c, lastAns.f2);
    endtask : qchk

    ////////////////////////////////////////////////////////////////////////////
    // Before first lock: gated queries refused, zone and edge answer defaults
    task automatic t_prelock;
        ltlsk_pkg::ltlsk_query_t gated[$] = '{ltlsk_pkg::LTLSK_Q_TIME, ltlsk_pkg::LTLSK_Q_DATE,
            ltlsk_pkg::LTLSK_Q_STRING, ltlsk_pkg::LTLSK_Q_ACC, ltlsk_pkg::LTLSK_Q_LDATE,
            ltlsk_pkg::LTLSK_Q_LDUR, ltlsk_pkg::LTLSK_Q_LSTATE};
        foreach (gated[i]) qchk(gated[i], 1'b1, 0, 0, 0, 0);
        chk("lock bit", 1'b0, powerupStatus[2]);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, 0, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_EDGE, 1'b0, 0, 0, 0, 0);
        chk("edge text", ltlsk_pkg::TXT_RIS, lastAns.text[79:48]);
    endtask : t_prelock

    // First lock sets status bit
    task automatic t_lock;
        bit ok;
        satLock = 1'b1;
        i_host.wait_lock(20, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end
        chk("lock bit", 1'b1, powerupStatus[2]);
    endtask : t_lock

    // Leap count, pending state, inserted and deleted seconds
    task automatic t_leap;
        gpsMinusUtc = 8'sd10;
        pulse(gpsMinusUtcValid);
        qchk(ltlsk_pkg::LTLSK_Q_ACC, 1'b0, 1, 10, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_LSTATE, 1'b0, 1, 0, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_LDATE, 1'b1, 0, 0, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_LDUR, 1'b1, 0, 0, 0, 0);
        {leapYear, leapMonth, leapDay, leapIns} = {12'd2005, 4'd12, 5'd31, 1'b1};
        qchk(ltlsk_pkg::LTLSK_Q_LSTATE, 1'b0, 1, 1, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_LDUR, 1'b0, 1, 61, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_LDATE, 1'b0, 3, 2005, 12, 31);
        tick(st(2005, 12, 31, 23, 59, 59));
        tick(st(2005, 12, 31, 23, 59, 60));
        qchk(ltlsk_pkg::LTLSK_Q_TIME, 1'b0, 3, 23, 59, 60);
        tick(st(2006, 1, 1, 0, 0, 0));
        leapIns = 1'b0;
        qchk(ltlsk_pkg::LTLSK_Q_ACC, 1'b0, 1, 11, 0, 0);
        {leapYear, leapMonth, leapDay, leapDel} = {12'd2006, 4'd6, 5'd30, 1'b1};
        qchk(ltlsk_pkg::LTLSK_Q_LDUR, 1'b0, 1, 59, 0, 0);
        tick(st(2006, 6, 30, 23, 59, 58));
        tick(st(2006, 7, 1, 0, 0, 0));
        leapDel = 1'b0;
        qchk(ltlsk_pkg::LTLSK_Q_ACC, 1'b0, 1, 10, 0, 0);
    endtask : t_leap

    // Zone offset: limits, default minutes, carries across dates
    task automatic t_zone;
        tick(st(2000, 12, 31, 23, 45, 10));
        setZone(5, 30, 1'b1, 1'b0);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, 5, 30, 0);
        qchk(ltlsk_pkg::LTLSK_Q_TIME, 1'b0, 3, 5, 15, 10);
        qchk(ltlsk_pkg::LTLSK_Q_DATE, 1'b0, 3, 2001, 1, 1);
        chk("local stamp", st(2001, 1, 1, 5, 15, 10), localNow);
        qchk(ltlsk_pkg::LTLSK_Q_STRING, 1'b0, 0, 0, 0, 0);
        chk("time text", {8'h22, "05:15:10", 8'h22}, lastAns.text);
        setZone(-3, 7, 1'b0, 1'b0);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, -3, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_TIME, 1'b0, 3, 20, 45, 10);
        setZone(20, -70, 1'b1, 1'b0);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, 12, -59, 0);
        setZone(2, 10, 1'b1, 1'b1);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, 3, 11, 0);
        tick(st(2001, 1, 1, 2, 0, 0));
        setZone(-12, -30, 1'b1, 1'b0);
        qchk(ltlsk_pkg::LTLSK_Q_DATE, 1'b0, 3, 2000, 12, 31);
        qchk(ltlsk_pkg::LTLSK_Q_TIME, 1'b0, 3, 13, 30, 0);
    endtask : t_zone

    // Edge select, then preset restores defaults and clears lock
    task automatic t_edge_preset;
        edgeFalling = 1'b1;
        pulse(edgeWrite);
        chk("pps falling", 1'b1, ppsFalling);
        qchk(ltlsk_pkg::LTLSK_Q_EDGE, 1'b0, 0, 0, 0, 0);
        chk("edge text", ltlsk_pkg::TXT_FALL, lastAns.text[79:48]);
        satLock = 1'b0;
        repeat (4) @(posedge clk);
        pulse(preset);
        chk("pps falling", 1'b0, ppsFalling);
        chk("lock bit", 1'b0, powerupStatus[2]);
        qchk(ltlsk_pkg::LTLSK_Q_ZONE, 1'b0, 2, 0, 0, 0);
        qchk(ltlsk_pkg::LTLSK_Q_TIME, 1'b1, 0, 0, 0, 0);
    endtask : t_edge_preset

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset_n, preset, satLock, secTick, gpsMinusUtcValid, leapIns, leapDel} = '0;
        {zoneWrite, zoneMinGiven, zoneRoundUp, edgeWrite, edgeFalling} = '0;
        {gpsMinusUtc, zoneHourIn, zoneMinIn, leapYear, leapMonth, leapDay} = '0;
        utcNow = st(2000, 1, 1, 0, 0, 0);
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_prelock();
        t_lock();
        t_leap();
        t_zone();
        t_edge_preset();
        print_verdict();
    end
endmodule : local_time_leap_second_keeper_tb_top
`default_nettype wire

// ==== testbench/ltlsk_host_model.sv ====
`default_nettype none
module ltlsk_host_model (
    input wire logic clk,
    input wire logic answerValid,
    input wire ltlsk_pkg::ltlsk_answer_t answer,
    input wire logic [7:0] powerupStatus,
    output var logic queryValid,
    output var ltlsk_pkg::ltlsk_query_t querySel
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Idle request lines at time zero
    initial begin
        queryValid = 1'b0;
        querySel = ltlsk_pkg::LTLSK_Q_TIME;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One query; answer taken in the cycle that it stands
    task automatic ask(input ltlsk_pkg::ltlsk_query_t sel, output ltlsk_pkg::ltlsk_answer_t ans,
        output bit ok);
        ok = 1'b0;
        ans = '0;
        @(posedge clk);
        #1;
        queryValid = 1'b1;
        querySel = sel;
        @(posedge clk);
        #1;
        queryValid = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (answerValid === 1'b1) begin
                ans = answer;
                ok = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask : ask

    ////////////////////////////////////////////////////////////////////////////
    // Poll first-lock status before trusting time queries
    task automatic wait_lock(input int limit, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = (powerupStatus[ltlsk_pkg::FIRST_LOCK_BIT] === 1'b1);
        end
    endtask : wait_lock
endmodule : ltlsk_host_model
`default_nettype wire
